/* shared/lkeng_pkg.sv */
/*
  Constants and carrier types of the VLAN and address lookup engine.
  Assumes a single core clock at 25 MHz and seven switch ports.
*/
package lkeng_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int LKENG_PORTS = 7;
  localparam int LKENG_PORT_W = 3;
  localparam int LKENG_VID_W = 12;
  localparam int LKENG_FID_W = 7;
  localparam int LKENG_PRIO_W = 3;
  localparam int LKENG_STAMP_W = 8;
  localparam int LKENG_CLK_PERIOD_NS = 40;
  localparam int LKENG_STAMP_PERIOD_NS = 1000000;
  localparam int LKENG_STAMP_TICK_CYCLES = LKENG_STAMP_PERIOD_NS / LKENG_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Control field positions and reset values
  // ----------------------------------------------------------------
  localparam int LKENG_CTRL0_VLAN_EN_BIT = 7;
  localparam int LKENG_CTRL0_DROP_INV_BIT = 6;
  localparam int LKENG_CTRL2_EGR_DYN_BIT = 5;
  localparam int LKENG_CTRL2_EGR_STA_BIT = 4;
  localparam logic [7:0] LKENG_CTRL0_RESET = 8'h40;
  localparam logic [7:0] LKENG_CTRL2_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Frame constants
  // ----------------------------------------------------------------
  localparam logic [15:0] LKENG_CTAG_TPID = 16'h8100;
  localparam logic [47:0] LKENG_RSVD_MC_BASE = 48'h0180C2000000;
  localparam logic [47:0] LKENG_RSVD_MC_MASK = 48'hFFFFFFFFFFF0;
  localparam logic [LKENG_VID_W-1:0] LKENG_NULL_VID = 12'h000;

  typedef logic [LKENG_PORTS-1:0] lkeng_pmask_t;

  // Frame header as seen by the engine; tag0 is the tag right after the source address.
  typedef struct packed {
    logic [LKENG_PORT_W-1:0] src_port;
    logic [47:0] da;
    logic [47:0] sa;
    logic tag0_present;
    logic [15:0] tag0_tpid;
    logic [LKENG_VID_W-1:0] tag0_vid;
  } lkeng_frame_t;

  typedef struct packed {
    logic valid;
    logic [LKENG_VID_W-1:0] vlan_identifier;
    logic [LKENG_FID_W-1:0] filter_identifier;
    logic fwd_option;
    lkeng_pmask_t members;
    lkeng_pmask_t untag;
  } lkeng_vlan_t;

  typedef struct packed {
    logic valid;
    logic [47:0] mac;
    logic use_fid;
    logic [LKENG_FID_W-1:0] filter_identifier;
    lkeng_pmask_t ports;
  } lkeng_static_t;

  typedef struct packed {
    logic valid;
    logic is_static;
    logic sa_filter;
    logic [LKENG_PRIO_W-1:0] prio;
    logic [LKENG_FID_W-1:0] filter_identifier;
    logic [47:0] mac;
    lkeng_pmask_t ports;
    logic [LKENG_STAMP_W-1:0] stamp;
  } lkeng_dyn_t;

  typedef struct packed {
    lkeng_frame_t frame;
    logic discard;
    lkeng_pmask_t fwd_ports;
    lkeng_pmask_t strip_ports;
    logic add_tag;
    logic [15:0] add_tpid;
    logic [LKENG_VID_W-1:0] vlan_identifier;
    logic prio_valid;
    logic [LKENG_PRIO_W-1:0] prio;
  } lkeng_result_t;

endpackage : lkeng_pkg

/* hdl/lkeng_engine.sv */
/*
  VLAN and address lookup engine with its ingress descriptor FIFO.
  Assumes descriptors and all configuration come from logic on CLOCK;
  tables are loaded through plain write strobes.
*/
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Descriptor FIFO
// ------------------------------------------------------------------
module lkeng_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("lkeng_fifo depth must be a power of two of at least 2.");
    end
  endgenerate

  // Handshakes and the next fill level.
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // Pointers, level and a registered ready that falls as the last slot fills.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_d;
      in_ready <= (count_d < (AW+1)'(DEPTH));
    end
  end

  // Storage.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule : lkeng_fifo

// ------------------------------------------------------------------
// Lookup engine
// ------------------------------------------------------------------
module lkeng_engine
  import lkeng_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int VT_DEPTH = 16,
  parameter int ST_DEPTH = 8,
  parameter int DT_DEPTH = 16,
  parameter int STAMP_TICK_CYCLES = LKENG_STAMP_TICK_CYCLES,
  localparam int VT_IW = $clog2(VT_DEPTH),
  localparam int ST_IW = $clog2(ST_DEPTH),
  localparam int DT_IW = $clog2(DT_DEPTH)
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic IN_VALID,
  input wire lkeng_frame_t IN_FRAME,
  output logic IN_READY,
  output logic OUT_VALID,
  output lkeng_result_t OUT_RESULT,
  input wire logic OUT_READY,
  input wire logic [7:0] LUE_CTRL0,
  input wire logic [7:0] LUE_CTRL2,
  input wire logic DOUBLE_TAG_EN,
  input wire logic [15:0] STAG_TPID,
  input wire logic DT_MCAST_TRAP_EN,
  input wire logic UNK_VID_FWD_EN,
  input wire lkeng_pmask_t UNK_VID_PORTS,
  input wire logic NULL_VID_REPL_EN,
  input wire logic [LKENG_PORT_W-1:0] HOST_PORT,
  input wire logic [LKENG_PORTS-1:0][15:0] PORT_DEF_TAG,
  input wire lkeng_pmask_t PORT_INGR_FILT,
  input wire lkeng_pmask_t PORT_PORT_DEFAULT_VLAN_IDENTIFIER_DROP,
  input wire lkeng_pmask_t PORT_UNTAG_DROP,
  input wire lkeng_pmask_t PORT_TAG_DROP,
  input wire lkeng_pmask_t PORT_PORT_DEFAULT_VLAN_IDENTIFIER_REPL,
  input wire logic VT_WR,
  input wire logic [VT_IW-1:0] VT_IDX,
  input wire lkeng_vlan_t VT_ENTRY,
  input wire logic ST_WR,
  input wire logic [ST_IW-1:0] ST_IDX,
  input wire lkeng_static_t ST_ENTRY,
  input wire logic DT_WR,
  input wire logic [DT_IW-1:0] DT_IDX,
  input wire lkeng_dyn_t DT_ENTRY,
  output logic [15:0] STAT_DISCARDS,
  output logic [15:0] STAT_LEARNED
);

  typedef enum {LKENG_IDLE, LKENG_VLAN, LKENG_ADDR, LKENG_OUT} lkeng_state_t;

  generate
    if (VT_DEPTH < 2 || VT_DEPTH > 4096 || (1 << VT_IW) != VT_DEPTH || ST_DEPTH < 2 || DT_DEPTH < 2
        || (1 << ST_IW) != ST_DEPTH || (1 << DT_IW) != DT_DEPTH || STAMP_TICK_CYCLES < 1) begin : g_bad_param
      $error("lkeng_engine table depths must be powers of two and the stamp tick positive.");
    end
  endgenerate

  lkeng_state_t state_q;
  lkeng_frame_t frame_q;
  lkeng_frame_t fifo_data;
  logic fifo_valid;
  logic pop;
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl2_q;
  lkeng_vlan_t vt_q [VT_DEPTH];
  lkeng_static_t st_q [ST_DEPTH];
  lkeng_dyn_t dt_q [DT_DEPTH];
  lkeng_vlan_t ventry_q;
  logic vhit_q;
  logic [LKENG_VID_W-1:0] vid_q;
  logic add_tag_q;
  logic tagged_q;
  logic [31:0] tick_q;
  logic [LKENG_STAMP_W-1:0] stamp_q;
  logic [DT_IW-1:0] rr_q;

  // Ingress tag stage signals.
  logic [LKENG_VID_W-1:0] port_default_vlan_identifier;
  logic in_ctag;
  logic in_outer;
  logic in_tagged;
  logic in_add;
  logic [LKENG_VID_W-1:0] in_vid;

  // Address stage signals.
  lkeng_pmask_t src_mask;
  lkeng_pmask_t host_mask;
  lkeng_pmask_t members;
  logic [LKENG_FID_W-1:0] filter_identifier;
  logic st_hit;
  lkeng_static_t st_sel;
  logic da_hit;
  lkeng_dyn_t da_sel;
  logic sa_hit;
  logic [DT_IW-1:0] sa_idx;
  logic free_found;
  logic [DT_IW-1:0] free_idx;
  logic sta_ok;
  logic addr_hit;
  logic trap;
  logic learn;
  logic refresh;
  logic [DT_IW-1:0] learn_idx;
  lkeng_result_t res;

  lkeng_fifo #(
    .WIDTH($bits(lkeng_frame_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst(RST),
    .in_valid(IN_VALID),
    .in_data(IN_FRAME),
    .in_ready(IN_READY),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(pop)
  );

  // ----------------------------------------------------------------
  // Control registers and table storage
  // ----------------------------------------------------------------

  // Control bytes follow their inputs; control two comes up with filtering off.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl0_q <= LKENG_CTRL0_RESET;
      ctrl2_q <= LKENG_CTRL2_RESET;
    end else begin
      ctrl0_q <= LUE_CTRL0;
      ctrl2_q <= LUE_CTRL2;
    end
  end

  // VLAN and static tables are written only by software.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < VT_DEPTH; i++) begin
        vt_q[i] <= '0;
      end
      for (int i = 0; i < ST_DEPTH; i++) begin
        st_q[i] <= '0;
      end
    end else begin
      if (VT_WR) begin
        vt_q[VT_IDX] <= VT_ENTRY;
      end
      if (ST_WR) begin
        st_q[ST_IDX] <= ST_ENTRY;
      end
    end
  end

  // Free-running stamp used to date learned entries.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tick_q <= '0;
      stamp_q <= '0;
    end else if (tick_q == 32'(STAMP_TICK_CYCLES - 1)) begin
      tick_q <= '0;
      stamp_q <= stamp_q + 1'b1;
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  // One descriptor at a time: take, VLAN lookup, address lookup, present.
  assign pop = (state_q == LKENG_IDLE) && fifo_valid;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_q <= LKENG_IDLE;
    end else begin
      unique case (state_q)
        LKENG_IDLE: begin
          if (fifo_valid) begin
            state_q <= LKENG_VLAN;
          end
        end
        LKENG_VLAN: begin
          state_q <= LKENG_ADDR;
        end
        LKENG_ADDR: begin
          state_q <= LKENG_OUT;
        end
        LKENG_OUT: begin
          if (OUT_READY) begin
            state_q <= LKENG_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Ingress tag handling and VLAN lookup
  // ----------------------------------------------------------------

  // Classify the first tag, decide on insertion and pick the lookup identifier.
  always_comb begin
    port_default_vlan_identifier = PORT_DEF_TAG[frame_q.src_port][LKENG_VID_W-1:0];
    in_ctag = frame_q.tag0_present && (frame_q.tag0_tpid == LKENG_CTAG_TPID);
    in_outer = frame_q.tag0_present && DOUBLE_TAG_EN && (frame_q.tag0_tpid == STAG_TPID);
    in_tagged = in_ctag || in_outer;
    in_add = ctrl0_q[LKENG_CTRL0_VLAN_EN_BIT] && (!in_tagged || (DOUBLE_TAG_EN && !in_outer));
    in_vid = in_add ? port_default_vlan_identifier : frame_q.tag0_vid;
    if (!ctrl0_q[LKENG_CTRL0_VLAN_EN_BIT]) begin
      in_vid = port_default_vlan_identifier;
    end else if (!in_add && NULL_VID_REPL_EN && in_vid == LKENG_NULL_VID) begin
      in_vid = port_default_vlan_identifier;
    end else if (!in_add && PORT_PORT_DEFAULT_VLAN_IDENTIFIER_REPL[frame_q.src_port] && in_vid != LKENG_NULL_VID) begin
      in_vid = port_default_vlan_identifier;
    end
  end

  // Capture the frame, then the VLAN entry for its identifier.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      frame_q <= '0;
      ventry_q <= '0;
      vhit_q <= 1'b0;
      vid_q <= '0;
      add_tag_q <= 1'b0;
      tagged_q <= 1'b0;
    end else if (pop) begin
      frame_q <= fifo_data;
    end else if (state_q == LKENG_VLAN) begin
      ventry_q <= vt_q[in_vid[VT_IW-1:0]];
      vhit_q <= vt_q[in_vid[VT_IW-1:0]].valid && (vt_q[in_vid[VT_IW-1:0]].vlan_identifier == in_vid);
      vid_q <= in_vid;
      add_tag_q <= in_add;
      tagged_q <= in_tagged;
    end
  end

  // ----------------------------------------------------------------
  // Address lookups
  // ----------------------------------------------------------------

  // Destination searched in both tables at once, source in the dynamic table.
  always_comb begin
    members = vhit_q ? ventry_q.members : '1;
    filter_identifier = vhit_q ? ventry_q.filter_identifier : '0;
    st_hit = 1'b0;
    st_sel = '0;
    da_hit = 1'b0;
    da_sel = '0;
    sa_hit = 1'b0;
    sa_idx = '0;
    free_found = 1'b0;
    free_idx = '0;
    for (int i = ST_DEPTH - 1; i >= 0; i--) begin
      if (st_q[i].valid && st_q[i].mac == frame_q.da) begin
        st_hit = 1'b1;
        st_sel = st_q[i];
      end
    end
    for (int i = DT_DEPTH - 1; i >= 0; i--) begin
      if (dt_q[i].valid && dt_q[i].filter_identifier == filter_identifier && dt_q[i].mac == frame_q.da) begin
        da_hit = 1'b1;
        da_sel = dt_q[i];
      end
      if (dt_q[i].valid && dt_q[i].filter_identifier == filter_identifier && dt_q[i].mac == frame_q.sa) begin
        sa_hit = 1'b1;
        sa_idx = DT_IW'(i);
      end
      if (!dt_q[i].valid) begin
        free_found = 1'b1;
        free_idx = DT_IW'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Forwarding decision
  // ----------------------------------------------------------------
  always_comb begin
    src_mask = lkeng_pmask_t'(1) << frame_q.src_port;
    host_mask = lkeng_pmask_t'(1) << HOST_PORT;
    sta_ok = st_hit && (!st_sel.use_fid || st_sel.filter_identifier == filter_identifier);
    addr_hit = sta_ok || da_hit;
    trap = DOUBLE_TAG_EN && DT_MCAST_TRAP_EN
           && ((frame_q.da & LKENG_RSVD_MC_MASK) == LKENG_RSVD_MC_BASE);
    res = '0;
    res.frame = frame_q;
    res.vlan_identifier = vid_q;
    res.add_tag = add_tag_q;
    res.add_tpid = DOUBLE_TAG_EN ? STAG_TPID : LKENG_CTAG_TPID;
    if (!ctrl0_q[LKENG_CTRL0_VLAN_EN_BIT]) begin
      res.fwd_ports = addr_hit ? (sta_ok ? st_sel.ports : da_sel.ports) : members;
    end else if (!vhit_q) begin
      if (UNK_VID_FWD_EN) begin
        res.fwd_ports = UNK_VID_PORTS;
      end else if (ctrl0_q[LKENG_CTRL0_DROP_INV_BIT]) begin
        res.discard = 1'b1;
      end else begin
        res.fwd_ports = host_mask;
      end
    end else if (!addr_hit || ventry_q.fwd_option) begin
      res.fwd_ports = members;
    end else if (sta_ok) begin
      res.fwd_ports = st_sel.ports;
      if (ctrl2_q[LKENG_CTRL2_EGR_STA_BIT]) begin
        res.fwd_ports = st_sel.ports & members;
      end
    end else begin
      res.fwd_ports = da_sel.ports;
      if (ctrl2_q[LKENG_CTRL2_EGR_DYN_BIT]) begin
        res.fwd_ports = da_sel.ports & members;
      end
    end
    if (trap) begin
      res.fwd_ports = host_mask;
      res.discard = 1'b0;
    end
    if (ctrl0_q[LKENG_CTRL0_VLAN_EN_BIT]) begin
      if (vhit_q && PORT_INGR_FILT[frame_q.src_port] && !ventry_q.members[frame_q.src_port]) begin
        res.discard = 1'b1;
      end
      if (PORT_PORT_DEFAULT_VLAN_IDENTIFIER_DROP[frame_q.src_port] && vid_q != PORT_DEF_TAG[frame_q.src_port][LKENG_VID_W-1:0]) begin
        res.discard = 1'b1;
      end
      if (PORT_UNTAG_DROP[frame_q.src_port] && !tagged_q) begin
        res.discard = 1'b1;
      end
      if (PORT_TAG_DROP[frame_q.src_port] && tagged_q) begin
        res.discard = 1'b1;
      end
    end
    if (sa_hit) begin
      res.prio_valid = 1'b1;
      res.prio = dt_q[sa_idx].prio;
      if (dt_q[sa_idx].sa_filter) begin
        res.discard = 1'b1;
      end
    end
    res.fwd_ports = res.discard ? '0 : (res.fwd_ports & ~src_mask);
    if (ctrl0_q[LKENG_CTRL0_VLAN_EN_BIT] && vhit_q && (add_tag_q || tagged_q)) begin
      res.strip_ports = res.fwd_ports & ventry_q.untag;
    end
  end

  // Learning happens only after a VLAN hit.
  assign learn = (state_q == LKENG_ADDR) && vhit_q && !sa_hit;
  assign refresh = (state_q == LKENG_ADDR) && vhit_q && sa_hit && !dt_q[sa_idx].is_static;
  assign learn_idx = free_found ? free_idx : rr_q;

  // Dynamic table: software writes win over learning on the same slot.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < DT_DEPTH; i++) begin
        dt_q[i] <= '0;
      end
      rr_q <= '0;
    end else begin
      if (learn) begin
        dt_q[learn_idx] <= '{valid: 1'b1, is_static: 1'b0, sa_filter: 1'b0, prio: '0, filter_identifier: filter_identifier,
                             mac: frame_q.sa, ports: src_mask, stamp: stamp_q};
        if (!free_found) begin
          rr_q <= rr_q + 1'b1;
        end
      end else if (refresh) begin
        dt_q[sa_idx].stamp <= stamp_q;
        dt_q[sa_idx].ports <= src_mask;
      end
      if (DT_WR) begin
        dt_q[DT_IDX] <= DT_ENTRY;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output and statistics
  // ----------------------------------------------------------------

  // Result is held stable while valid until the consumer takes it.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      OUT_VALID <= 1'b0;
      OUT_RESULT <= '0;
    end else if (state_q == LKENG_ADDR) begin
      OUT_VALID <= 1'b1;
      OUT_RESULT <= res;
    end else if (OUT_VALID && OUT_READY) begin
      OUT_VALID <= 1'b0;
    end
  end

  // Saturating counts of discarded frames and learned addresses.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      STAT_DISCARDS <= '0;
      STAT_LEARNED <= '0;
    end else if (state_q == LKENG_ADDR) begin
      if (res.discard && STAT_DISCARDS != 16'hFFFF) begin
        STAT_DISCARDS <= STAT_DISCARDS + 1'b1;
      end
      if (learn && STAT_LEARNED != 16'hFFFF) begin
        STAT_LEARNED <= STAT_LEARNED + 1'b1;
      end
    end
  end

endmodule : lkeng_engine

/* testbench/lkeng_engine_checker.sv */
/*
  Port assertions for the lookup engine.
  Assumes controls stay steady while a frame is in flight.
*/
`timescale 1ns/1ps
module lkeng_engine_checker
  import lkeng_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic IN_VALID,
  input wire logic IN_READY,
  input wire logic OUT_VALID,
  input wire lkeng_result_t OUT_RESULT,
  input wire logic OUT_READY,
  input wire logic [7:0] LUE_CTRL0,
  input wire lkeng_pmask_t PORT_TAG_DROP
);
  // ------
  // Result stream properties
  // ------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  lkeng_frame_t f;
  // The frame header of the result on offer.
  assign f = OUT_RESULT.frame;
  out_hold_a: assert property (
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_RESULT)) else $error("result changed while stalled");
  latency_a: assert property (
    IN_VALID && IN_READY |-> ##[4:1000] OUT_VALID) else $error("no result after a taken frame");
  reset_idle_a: assert property (
    disable iff (1'b0) RST |-> !IN_READY && !OUT_VALID) else $error("stream active in reset");
  discard_zero_a: assert property (
    OUT_VALID && OUT_RESULT.discard |-> OUT_RESULT.fwd_ports == '0) else $error("discarded frame has ports");
  ingress_excl_a: assert property (
    OUT_VALID |-> !OUT_RESULT.fwd_ports[f.src_port]) else $error("frame sent back to ingress port");
  strip_sub_a: assert property (
    OUT_VALID |-> (OUT_RESULT.strip_ports & ~OUT_RESULT.fwd_ports) == '0) else $error("strip outside forward set");
  tag_drop_a: assert property (
    OUT_VALID && f.tag0_present && f.tag0_tpid == LKENG_CTAG_TPID && PORT_TAG_DROP[f.src_port]
    |-> OUT_RESULT.discard) else $error("tagged frame not dropped");
  vlan_off_a: assert property (
    OUT_VALID && !LUE_CTRL0[LKENG_CTRL0_VLAN_EN_BIT] |-> !OUT_RESULT.add_tag) else $error("tag added with vlan off");
endmodule : lkeng_engine_checker

bind lkeng_engine lkeng_engine_checker u_chk (.CLOCK, .RST, .IN_VALID, .IN_READY, .OUT_VALID, .OUT_RESULT,
  .OUT_READY, .LUE_CTRL0, .PORT_TAG_DROP);

/* testbench/lkeng_port_sink.sv */
/*
  Egress port MAC model that takes engine results.
  Assumes the engine clock; stall comes from the bench.
*/
`timescale 1ns/1ps
module lkeng_port_sink
  import lkeng_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic valid,
  input wire lkeng_result_t result,
  output logic ready,
  output int got,
  output lkeng_result_t last_q
);
  // Ready drops while the bench asks the MACs to hold back.
  assign ready = !stall;
  // Every accepted result is counted; the last one is kept.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      got <= 0;
      last_q <= '0;
    end else if (valid && ready) begin
      got <= got + 1;
      last_q <= result;
    end
  end
endmodule : lkeng_port_sink

/* testbench/tb_vlan_address_lookup_engine.sv */
/*
  Self-checking bench for the lookup engine.
  Assumes the package, engine, checker and sink are compiled first.
*/
`timescale 1ns/1ps
module tb_vlan_address_lookup_engine;
  import lkeng_pkg::*;
  localparam logic [47:0] DA1 = 48'h02000000000A, DA2 = 48'h02000000000B, SA1 = 48'h02000000001C;
  localparam logic [47:0] SA2 = 48'h0200000000A2;
  logic CLOCK = 1'h0, RST = 1'h0, IN_VALID = 1'h0, IN_READY, OUT_VALID, OUT_READY, stall = 1'h0;
  logic UNK_VID_FWD_EN = 1'h0, VT_WR = 1'h0, ST_WR = 1'h0, DT_WR = 1'h0;
  logic DOUBLE_TAG_EN = 1'h0, DT_MCAST_TRAP_EN = 1'h0, NULL_VID_REPL_EN = 1'h0;
  logic [2:0] ST_IDX = 3'h3;
  logic [3:0] DT_IDX = 4'h7;
  lkeng_pmask_t PORT_PORT_DEFAULT_VLAN_IDENTIFIER_DROP = '0;
  logic [7:0] LUE_CTRL0 = 8'h00, LUE_CTRL2 = 8'h00;
  logic [15:0] STAT_DISCARDS, STAT_LEARNED;
  lkeng_frame_t IN_FRAME = '0;
  lkeng_result_t OUT_RESULT, res;
  lkeng_vlan_t VT_ENTRY = '0;
  lkeng_static_t ST_ENTRY = '0;
  lkeng_dyn_t DT_ENTRY = '0;
  lkeng_pmask_t PORT_INGR_FILT = '0, PORT_TAG_DROP = '0, PORT_UNTAG_DROP = '0, PORT_PORT_DEFAULT_VLAN_IDENTIFIER_REPL = '0;
  int failures = 0, n_compared = 0, got;

  lkeng_engine #(.STAMP_TICK_CYCLES(4)) dut (.CLOCK, .RST, .IN_VALID, .IN_FRAME, .IN_READY, .OUT_VALID,
    .OUT_RESULT, .OUT_READY, .LUE_CTRL0, .LUE_CTRL2, .DOUBLE_TAG_EN, .STAG_TPID(16'h88A8),
    .DT_MCAST_TRAP_EN, .UNK_VID_FWD_EN, .UNK_VID_PORTS(7'h06), .NULL_VID_REPL_EN,
    .HOST_PORT(3'h6), .PORT_DEF_TAG({7{16'h0005}}), .PORT_INGR_FILT, .PORT_PORT_DEFAULT_VLAN_IDENTIFIER_DROP,
    .PORT_UNTAG_DROP, .PORT_TAG_DROP, .PORT_PORT_DEFAULT_VLAN_IDENTIFIER_REPL, .VT_WR, .VT_IDX(4'h5), .VT_ENTRY, .ST_WR,
    .ST_IDX, .ST_ENTRY, .DT_WR, .DT_IDX, .DT_ENTRY, .STAT_DISCARDS, .STAT_LEARNED);
  lkeng_port_sink u_sink (.clk(CLOCK), .rst(RST), .stall, .valid(OUT_VALID), .result(OUT_RESULT),
    .ready(OUT_READY), .got, .last_q(res));

  // The core clock toggles every half period of 40 ns.
  always #20 CLOCK = ~CLOCK;

  // ------
  // Helpers
  // ------
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic lkeng_frame_t fr(input logic [2:0] p, input logic [47:0] da, sa, input logic tg,
    input logic [11:0] v);
    return '{p, da, sa, tg, LKENG_CTAG_TPID, v};
  endfunction : fr
  // Offers one frame, then waits for its result at the sink.
  task automatic xfer(input lkeng_frame_t f);
    int n0;
    n0 = got;
    IN_VALID <= 1'h1;
    IN_FRAME <= f;
    @(posedge CLOCK);
    while (IN_READY !== 1'h1) @(posedge CLOCK);
    IN_VALID <= 1'h0;
    repeat (200) if (got == n0) @(posedge CLOCK);
    chk("result", 16'(got - n0), 16'h0001);
  endtask : xfer
  task automatic exp(input logic d, input lkeng_pmask_t p);
    chk("discard", res.discard, d);
    chk("fwd_ports", res.fwd_ports, p);
  endtask : exp

  // ------
  // Scenarios
  // ------
  task automatic t_forward();
    xfer(fr(3'h0, 48'h0200000000EE, SA1, 1'h0, 12'h000));
    exp(1'h0, 7'h1E);
    chk("add_tag", res.add_tag, 1'h0);
    LUE_CTRL0 <= 8'h80;
    xfer(fr(3'h0, DA1, SA1, 1'h0, 12'h000));
    exp(1'h0, 7'h2C);
    chk("vid", res.vlan_identifier, 12'h005);
    xfer(fr(3'h0, DA2, SA1, 1'h0, 12'h000));
    exp(1'h0, 7'h10);
    chk("strip_ports", res.strip_ports, 7'h10);
    LUE_CTRL2 <= 8'h10;
    xfer(fr(3'h0, DA1, SA1, 1'h0, 12'h000));
    exp(1'h0, 7'h0C);
    LUE_CTRL2 <= 8'h00;
    LUE_CTRL0 <= 8'hC0;
    xfer(fr(3'h0, DA2, SA1, 1'h1, 12'h009));
    exp(1'h1, 7'h00);
    LUE_CTRL0 <= 8'h80;
    xfer(fr(3'h0, DA2, SA1, 1'h1, 12'h009));
    exp(1'h0, 7'h40);
    LUE_CTRL0 <= 8'hC0;
    UNK_VID_FWD_EN <= 1'h1;
    xfer(fr(3'h0, DA2, SA1, 1'h1, 12'h009));
    exp(1'h0, 7'h06);
    UNK_VID_FWD_EN <= 1'h0;
    $display("test forward done");
  endtask : t_forward
  task automatic t_learn();
    logic [15:0] l0;
    l0 = STAT_LEARNED;
    xfer(fr(3'h2, DA2, SA2, 1'h0, 12'h000));
    chk("learned", STAT_LEARNED, l0 + 16'h0001);
    xfer(fr(3'h3, DA2, SA2, 1'h0, 12'h000));
    xfer(fr(3'h0, SA2, SA1, 1'h0, 12'h000));
    exp(1'h0, 7'h08);
    chk("prio_valid", res.prio_valid, 1'h1);
    chk("learned", STAT_LEARNED, l0 + 16'h0001);
    $display("test learn done");
  endtask : t_learn
  task automatic t_port_ctl();
    logic [15:0] d0;
    d0 = STAT_DISCARDS;
    PORT_TAG_DROP <= 7'h01;
    xfer(fr(3'h0, DA2, SA1, 1'h1, 12'h005));
    exp(1'h1, 7'h00);
    PORT_TAG_DROP <= 7'h00;
    PORT_UNTAG_DROP <= 7'h01;
    xfer(fr(3'h0, DA2, SA1, 1'h0, 12'h000));
    exp(1'h1, 7'h00);
    PORT_UNTAG_DROP <= 7'h00;
    PORT_INGR_FILT <= 7'h40;
    xfer(fr(3'h6, DA2, SA1, 1'h0, 12'h000));
    exp(1'h1, 7'h00);
    chk("discards", STAT_DISCARDS, d0 + 16'h0003);
    PORT_INGR_FILT <= 7'h00;
    PORT_PORT_DEFAULT_VLAN_IDENTIFIER_REPL <= 7'h01;
    xfer(fr(3'h0, DA2, SA1, 1'h1, 12'h009));
    chk("vid", res.vlan_identifier, 12'h005);
    PORT_PORT_DEFAULT_VLAN_IDENTIFIER_REPL <= 7'h00;
    $display("test port_ctl done");
  endtask : t_port_ctl
  task automatic t_double();
    lkeng_frame_t f;
    NULL_VID_REPL_EN <= 1'h1;
    xfer(fr(3'h0, DA2, SA1, 1'h1, 12'h000));
    chk("vid", res.vlan_identifier, 12'h005);
    NULL_VID_REPL_EN <= 1'h0;
    LUE_CTRL0 <= 8'h80;
    PORT_PORT_DEFAULT_VLAN_IDENTIFIER_DROP <= 7'h01;
    xfer(fr(3'h0, DA2, SA1, 1'h1, 12'h009));
    exp(1'h1, 7'h00);
    PORT_PORT_DEFAULT_VLAN_IDENTIFIER_DROP <= 7'h00;
    DOUBLE_TAG_EN <= 1'h1;
    f = fr(3'h0, DA2, SA1, 1'h1, 12'h009);
    f.tag0_tpid = 16'h88A8;
    xfer(f);
    exp(1'h0, 7'h40);
    xfer(fr(3'h0, DA2, SA1, 1'h1, 12'h009));
    chk("add_tag", res.add_tag, 1'h1);
    chk("add_tpid", res.add_tpid, 16'h88A8);
    exp(1'h0, 7'h10);
    DT_MCAST_TRAP_EN <= 1'h1;
    xfer(fr(3'h0, 48'h0180C2000003, SA1, 1'h0, 12'h000));
    exp(1'h0, 7'h40);
    DT_MCAST_TRAP_EN <= 1'h0;
    DOUBLE_TAG_EN <= 1'h0;
    $display("test double done");
  endtask : t_double
  task automatic t_fill();
    int n, g0;
    n = 0;
    g0 = got;
    stall <= 1'h1;
    IN_VALID <= 1'h1;
    IN_FRAME <= fr(3'h1, DA2, SA1, 1'h0, 12'h000);
    repeat (40) begin
      @(posedge CLOCK);
      if (IN_READY === 1'h1) n++;
    end
    IN_VALID <= 1'h0;
    chk("full refuses", IN_READY, 1'h0);
    chk("accepted", 16'(n), 16'h0011);
    stall <= 1'h0;
    repeat (300) @(posedge CLOCK);
    chk("results", 16'(got - g0), 16'(n));
    $display("test fill done");
  endtask : t_fill

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // Reset, table load, then every scenario in turn.
  initial begin
    RST <= 1'h1;
    repeat (5) @(posedge CLOCK);
    RST <= 1'h0;
    repeat (2) @(posedge CLOCK);
    VT_WR <= 1'h1;
    VT_ENTRY <= '{1'h1, 12'h005, 7'h01, 1'h0, 7'h1F, 7'h10};
    ST_WR <= 1'h1;
    ST_ENTRY <= '{1'h1, DA1, 1'h0, 7'h00, 7'h2C};
    DT_WR <= 1'h1;
    DT_ENTRY <= '{1'h1, 1'h0, 1'h0, 3'h0, 7'h01, DA2, 7'h10, 8'h00};
    @(posedge CLOCK);
    VT_WR <= 1'h0;
    ST_WR <= 1'h0;
    DT_WR <= 1'h0;
    @(posedge CLOCK);
    t_forward();
    t_learn();
    t_port_ctl();
    t_double();
    t_fill();
    final_report();
  end

  // A hang is cut short well past the expected run length.
  initial begin
    #400000;
    failures++;
    final_report();
  end
endmodule : tb_vlan_address_lookup_engine
